// File: hrp_pkg.sv
// package: constants and types for the hub role, reset and power control block
package hrp_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned NUM_PORTS       = 4;
    localparam int unsigned POR_HOLD_US     = 100;
    localparam int unsigned POR_HOLD_CYC    = (POR_HOLD_US * (CLK_HZ / 1_000_000));
    localparam int unsigned L2_ENTRY_US     = 3000;
    localparam int unsigned L2_EXIT_US      = 2000;
    localparam int unsigned L1_ENTRY_NS     = 10_000;
    localparam int unsigned L1_EXIT_NS      = 50_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    localparam int unsigned L2_ENTRY_CYC    = L2_ENTRY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned L2_EXIT_CYC     = L2_EXIT_US * (CLK_HZ / 1_000_000);
    // longest times round down, then one cycle of margin below the bound
    localparam int unsigned L1_ENTRY_CYC    = (L1_ENTRY_NS / CLK_PERIOD_NS) - 1;
    localparam int unsigned L1_EXIT_CYC     = (L1_EXIT_NS / CLK_PERIOD_NS) - 1;
    localparam int unsigned CNT_W           = 16;
    localparam logic [7:0]  CFG_END_REG     = 8'hff;
    localparam logic [6:0]  USB_ADDR_DFLT   = 7'h00;

    typedef enum logic [2:0] {
        HRP_L0,
        HRP_L1_ENTER,
        HRP_L1,
        HRP_L1_EXIT,
        HRP_L2_ENTER,
        HRP_L2,
        HRP_L2_EXIT
    } hrp_lpm_e;
endpackage

// File: hrp_ctrl.sv
// hub role swap, reset handling and link power state control
// What this block does
// - attach input high enables ss phy clock for that port, low disables it
// - swap exchanges upstream only with port 1; default port 0 upstream
// - swap accepted from config registers after the config stage, usb command and swap pin
// - swap pin low selects default role, high selects swapped role
// - state output low default, high swapped, same for every source
// - power-on timer holds internal reset for its configured duration
// - external reset asserted puts device into minimal current standby
// - external reset disables phy and tristates differential pairs
// - external reset ends all transactions, no state kept
// - external reset returns all internal registers to defaults
// - external reset stops crystal oscillator and halts pll
// - upstream bus reset sets address 0 and unconfigured state
// - bus reset moves a suspended device to active
// - upstream bus reset is never forwarded downstream
// - link power states l0, l1 and l2 supported
// - l2 entry about 3 ms, exit about 2 ms from resume start
// - l1 entry under 10 us, exit under 50 us
// - config stage ends when register 0xff is written
module hrp_ctrl
    import hrp_pkg::*;
#(
    parameter int unsigned NPORT      = hrp_pkg::NUM_PORTS,
    parameter int unsigned POR_CYC    = hrp_pkg::POR_HOLD_CYC,
    parameter int unsigned L2_IN_CYC  = hrp_pkg::L2_ENTRY_CYC,
    parameter int unsigned L2_OUT_CYC = hrp_pkg::L2_EXIT_CYC
)
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [NPORT-1:0]      attach_i,
    input  wire logic                  role_swap_cmd_in_i,
    input  wire logic                  cfg_wr_i,
    input  wire logic [7:0]            cfg_addr_i,
    input  wire logic                  cfg_swap_i,
    input  wire logic                  cfg_swap_wr_i,
    input  wire logic                  usb_swap_i,
    input  wire logic                  usb_swap_wr_i,
    input  wire logic                  swap_ack_i,
    input  wire logic                  bus_reset_i,
    input  wire logic                  l1_req_i,
    input  wire logic                  l2_req_i,
    input  wire logic                  resume_i,
    output logic      [NPORT-1:0]      phy_clk_en_o,
    output logic                       phy_en_o,
    output logic                       diff_oe_o,
    output logic                       osc_en_o,
    output logic                       pll_en_o,
    output logic                       standby_o,
    output logic                       int_rst_n_o,
    output logic                       cfg_stage_o,
    output logic                       swap_req_o,
    output logic                       role_swap_state_out_o,
    output logic                       upstream_sel_o,
    output logic      [6:0]            usb_addr_o,
    output logic                       configured_o,
    output logic                       ds_reset_o,
    output hrp_pkg::hrp_lpm_e          lpm_state_o
);
    import hrp_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [NPORT-1:0] att_s1;
        logic [NPORT-1:0] att_s2;
        logic             cmd_s1;
        logic             cmd_s2;
        logic             cmd_prev;
        logic [CNT_W-1:0] por_cnt;
        logic             int_rst_n;
        logic             cfg_stage;
        logic             swap_tgt;
        logic             swap_cur;
        logic [6:0]       usb_addr;
        logic             configured;
        hrp_lpm_e         lpm;
        logic [CNT_W-1:0] lpm_cnt;
    } hrp_state_s;

    hrp_state_s st_ff;
    hrp_state_s nxt_st;

    // one-hot-free helper: count reached a terminal value
    function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int unsigned lim);
        cnt_done = (c >= CNT_W'(lim));
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        // two-flop synchronisers; only s2 is consumed downstream
        nxt_st.att_s1   = attach_i;
        nxt_st.att_s2   = st_ff.att_s1;
        nxt_st.cmd_s1   = role_swap_cmd_in_i;
        nxt_st.cmd_s2   = st_ff.cmd_s1;
        nxt_st.cmd_prev = st_ff.cmd_s2;

        // internal reset held until the power-on timer expires
        if (!cnt_done(st_ff.por_cnt, POR_CYC))
        begin
            nxt_st.por_cnt = st_ff.por_cnt + 1'b1;
        end
        nxt_st.int_rst_n = cnt_done(st_ff.por_cnt, POR_CYC);

        // config stage closes on a write to the end register
        if (cfg_wr_i && cfg_addr_i == CFG_END_REG)
        begin
            nxt_st.cfg_stage = 1'b0;
        end

        // last writer wins; pin acts on its edges so a register can override it
        if (st_ff.cmd_s2 != st_ff.cmd_prev)
        begin
            nxt_st.swap_tgt = st_ff.cmd_s2;
        end
        if (cfg_swap_wr_i && !st_ff.cfg_stage)
        begin
            nxt_st.swap_tgt = cfg_swap_i;
        end
        if (usb_swap_wr_i)
        begin
            nxt_st.swap_tgt = usb_swap_i;
        end
        // reported state follows only once the port mux confirms
        if (swap_ack_i)
        begin
            nxt_st.swap_cur = st_ff.swap_tgt;
        end

        // link power states with fixed transition latencies
        nxt_st.lpm_cnt = st_ff.lpm_cnt + 1'b1;
        unique case (st_ff.lpm)
            HRP_L0:
            begin
                nxt_st.lpm_cnt = '0;
                if (l1_req_i)
                begin
                    nxt_st.lpm = HRP_L1_ENTER;
                end
                else if (l2_req_i)
                begin
                    nxt_st.lpm = HRP_L2_ENTER;
                end
            end
            HRP_L1_ENTER:
            begin
                if (cnt_done(st_ff.lpm_cnt, L1_ENTRY_CYC - 1))
                begin
                    nxt_st.lpm = HRP_L1;
                end
            end
            HRP_L1:
            begin
                nxt_st.lpm_cnt = '0;
                if (resume_i)
                begin
                    nxt_st.lpm = HRP_L1_EXIT;
                end
            end
            HRP_L1_EXIT:
            begin
                if (cnt_done(st_ff.lpm_cnt, L1_EXIT_CYC - 1))
                begin
                    nxt_st.lpm = HRP_L0;
                end
            end
            HRP_L2_ENTER:
            begin
                if (cnt_done(st_ff.lpm_cnt, L2_IN_CYC - 1))
                begin
                    nxt_st.lpm = HRP_L2;
                end
            end
            HRP_L2:
            begin
                nxt_st.lpm_cnt = '0;
                if (resume_i)
                begin
                    nxt_st.lpm = HRP_L2_EXIT;
                end
            end
            HRP_L2_EXIT:
            begin
                if (cnt_done(st_ff.lpm_cnt, L2_OUT_CYC - 1))
                begin
                    nxt_st.lpm = HRP_L0;
                end
            end
            // spare encoding: fall back to full power rather than hang
            default:
            begin
                nxt_st.lpm     = HRP_L0;
                nxt_st.lpm_cnt = '0;
            end
        endcase

        // bus reset: default address, unconfigured, suspended wakes at once
        if (bus_reset_i)
        begin
            nxt_st.usb_addr   = USB_ADDR_DFLT;
            nxt_st.configured = 1'b0;
            nxt_st.lpm        = HRP_L0;
            nxt_st.lpm_cnt    = '0;
        end
    end

    // ---------------------------------------------------------------
    // registers; external reset clears everything to defaults
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff           <= '0;
            st_ff.cfg_stage <= 1'b1;
            st_ff.usb_addr  <= USB_ADDR_DFLT;
            st_ff.lpm       <= HRP_L0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // the reset pin gates analog enables directly so standby is immediate
    assign phy_en_o      = rst_n_i;
    assign diff_oe_o     = rst_n_i;
    assign osc_en_o      = rst_n_i;
    assign pll_en_o      = rst_n_i;
    assign standby_o     = !rst_n_i;
    assign phy_clk_en_o  = st_ff.att_s2 & {NPORT{rst_n_i}};
    assign int_rst_n_o   = st_ff.int_rst_n;
    assign cfg_stage_o   = st_ff.cfg_stage;
    assign swap_req_o    = st_ff.swap_tgt;
    assign upstream_sel_o        = st_ff.swap_cur;
    assign role_swap_state_out_o = st_ff.swap_cur;
    assign usb_addr_o    = st_ff.usb_addr;
    assign configured_o  = st_ff.configured;
    assign ds_reset_o    = 1'b0;
    assign lpm_state_o   = st_ff.lpm;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_ack;
        swap_ack_i;
    endsequence

    // last sampled cycle at which a sleep transition may still be finishing
    localparam int L1_IN_LAST  = int'(L1_ENTRY_CYC);
    localparam int L1_OUT_LAST = int'(L1_EXIT_CYC);

    // sleep entry and exit each walk through one transit state, bounded
    sequence s_l1_enter_path;
        lpm_state_o == HRP_L1_ENTER ##[1:L1_IN_LAST] lpm_state_o == HRP_L1;
    endsequence

    sequence s_l1_exit_path;
        lpm_state_o == HRP_L1_EXIT ##[1:L1_OUT_LAST] lpm_state_o == HRP_L0;
    endsequence

    a_attach_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        phy_clk_en_o == $past(attach_i, 2) || $past(!rst_n_i, 2))
        else $error("phy clock gate does not follow attach");
    a_swap_after_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(role_swap_state_out_o) |-> $past(swap_ack_i))
        else $error("swap state changed without exchange");
    a_swap_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ack |=> role_swap_state_out_o == $past(swap_req_o))
        else $error("swap state not the requested role");
    a_pin_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(role_swap_cmd_in_i) && !cfg_swap_wr_i && !usb_swap_wr_i
        ##1 !cfg_swap_wr_i && !usb_swap_wr_i ##1 !cfg_swap_wr_i && !usb_swap_wr_i
        ##1 !cfg_swap_wr_i && !usb_swap_wr_i && role_swap_cmd_in_i
        |=> swap_req_o)
        else $error("swap pin high did not select swapped role");
    a_bus_rst_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_reset_i |=> usb_addr_o == USB_ADDR_DFLT && !configured_o)
        else $error("bus reset did not clear address");
    a_bus_rst_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_reset_i |=> lpm_state_o == HRP_L0)
        else $error("bus reset did not wake device");
    a_no_ds_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_reset_i |-> !ds_reset_o)
        else $error("bus reset forwarded downstream");
    a_l1_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lpm_state_o == HRP_L0 && l1_req_i && !bus_reset_i |=> s_l1_enter_path)
        else $error("l1 entry too slow");
    a_l1_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lpm_state_o == HRP_L1 && resume_i && !bus_reset_i |=> s_l1_exit_path)
        else $error("l1 exit too slow");
    a_cfg_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_wr_i && cfg_addr_i == CFG_END_REG |=> !cfg_stage_o)
        else $error("config stage not ended");
    a_por_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(int_rst_n_o) |-> st_ff.por_cnt >= CNT_W'(POR_CYC))
        else $error("internal reset released early");
    a_standby: assert property (@(posedge clk_i)
        !rst_n_i |-> standby_o && !pll_en_o && !osc_en_o && !diff_oe_o)
        else $error("standby not entered under reset");

    // analog enables all return the moment the reset pin lets go
    a_phy_run: assert property (@(posedge clk_i)
        rst_n_i |-> phy_en_o && diff_oe_o && osc_en_o && pll_en_o && !standby_o)
        else $error("phy or clocks off outside reset");

    // the usb command lands on the next edge whatever else is asked
    a_usb_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        usb_swap_wr_i |=> swap_req_o == $past(usb_swap_i))
        else $error("usb swap command not taken");

    // the register source counts only once configuration has ended
    a_cfg_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_swap_wr_i && !usb_swap_wr_i && !cfg_stage_o
        |=> swap_req_o == $past(cfg_swap_i))
        else $error("register swap not taken");

    // while configuring, a register write on its own leaves the request alone
    a_cfg_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_swap_wr_i && cfg_stage_o && !usb_swap_wr_i && st_ff.cmd_s2 == st_ff.cmd_prev
        |=> $stable(swap_req_o))
        else $error("register swap taken during configuration");

    // upstream choice and reported role come from the same flop
    a_upstream_role: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        upstream_sel_o == role_swap_state_out_o)
        else $error("upstream port and reported role differ");

    // a suspend request from full power starts the suspend walk
    a_l2_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lpm_state_o == HRP_L0 && l2_req_i && !l1_req_i && !bus_reset_i |=>
        lpm_state_o == HRP_L2_ENTER)
        else $error("l2 request not taken");

    // suspend transit counters never run past their latency
    a_l2_enter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lpm_state_o == HRP_L2_ENTER |-> st_ff.lpm_cnt < CNT_W'(L2_IN_CYC))
        else $error("l2 entry overran");
    a_l2_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lpm_state_o == HRP_L2_EXIT |-> st_ff.lpm_cnt < CNT_W'(L2_OUT_CYC))
        else $error("l2 exit overran");
endmodule

// File: hrp_mux_model.sv
// partner model: port mux that acknowledges a role exchange after a delay
module hrp_mux_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       swap_req_i,
    input  wire logic [3:0] dly_i,
    output logic            swap_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       done_ff;
    logic [3:0] cnt_ff;
    // one-cycle ack once lanes follow the request; dly_i emulates a slow mux
    always @(negedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            swap_ack_o <= 1'h0;
            done_ff    <= 1'h0;
            cnt_ff     <= 4'h0;
        end
        else
        begin
            swap_ack_o <= 1'h0;
            if (swap_req_i !== done_ff)
            begin
                if (cnt_ff >= dly_i)
                begin
                    swap_ack_o <= 1'h1;
                    done_ff    <= swap_req_i;
                    cnt_ff     <= 4'h0;
                end
                else
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end
endmodule

// File: hrp_ctrl_tb_top.sv
// testbench: role swap, reset and link power checks for hrp_ctrl
module hrp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hrp_pkg::*;
    localparam int unsigned POR_SIM = 8;
    localparam int unsigned L2_SIM  = 8;
    logic        clk_i = 1'h0, rst_n_i = 1'h0, swap_ack_i;
    logic [3:0]  attach_i = 4'h0, dly = 4'h0, phy_clk_en_o;
    logic [7:0]  cfg_addr_i = 8'h00;
    logic        role_swap_cmd_in_i = 1'h0, cfg_wr_i = 1'h0, cfg_swap_i = 1'h0;
    logic        cfg_swap_wr_i = 1'h0, usb_swap_i = 1'h0, usb_swap_wr_i = 1'h0;
    logic        bus_reset_i = 1'h0, l1_req_i = 1'h0, l2_req_i = 1'h0, resume_i = 1'h0;
    logic        phy_en_o, diff_oe_o, osc_en_o, pll_en_o, standby_o, int_rst_n_o;
    logic        cfg_stage_o, swap_req_o, role_swap_state_out_o, upstream_sel_o;
    logic        configured_o, ds_reset_o;
    logic [6:0]  usb_addr_o;
    hrp_lpm_e    lpm_state_o;
    logic [31:0] seed = 32'h664e, r;
    int          n_mismatch = 0, checks_done = 0, cyc = 0, n;

    always #50 clk_i = ~clk_i;

    // short timer counts keep the run brief; expectations use the same values
    hrp_ctrl #(.POR_CYC(POR_SIM), .L2_IN_CYC(L2_SIM), .L2_OUT_CYC(L2_SIM)) DUT (
        .clk_i, .rst_n_i, .attach_i, .role_swap_cmd_in_i, .cfg_wr_i, .cfg_addr_i,
        .cfg_swap_i, .cfg_swap_wr_i, .usb_swap_i, .usb_swap_wr_i, .swap_ack_i,
        .bus_reset_i, .l1_req_i, .l2_req_i, .resume_i, .phy_clk_en_o, .phy_en_o,
        .diff_oe_o, .osc_en_o, .pll_en_o, .standby_o, .int_rst_n_o, .cfg_stage_o,
        .swap_req_o, .role_swap_state_out_o, .upstream_sel_o, .usb_addr_o,
        .configured_o, .ds_reset_o, .lpm_state_o);

    hrp_mux_model MUX (.clk_i, .rst_n_i, .swap_req_i(swap_req_o), .dly_i(dly),
        .swap_ack_o(swap_ack_i));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_lpm(string nm, hrp_lpm_e e, hrp_lpm_e g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(int k);
        repeat (k) @(negedge clk_i);
    endtask

    // reset is held four cycles; attach high shows the gate wins over it
    task automatic do_reset();
        @(negedge clk_i);
        rst_n_i = 1'h0;
        attach_i = 4'hf;
        #1;
        chk("phy_osc_pll", 8'h00, {phy_en_o, diff_oe_o, osc_en_o, pll_en_o});
        chk("standby", 8'h01, {7'h0, standby_o});
        tick(4);
        chk("clk_en_rst", 8'h00, {4'h0, phy_clk_en_o});
        chk("regs_rst", 8'h08, {swap_req_o, role_swap_state_out_o, upstream_sel_o,
            configured_o, cfg_stage_o, int_rst_n_o, ds_reset_o, 1'h0});
        chk("addr_rst", 8'h00, {1'h0, usb_addr_o});
        chk_lpm("lpm_rst", HRP_L0, lpm_state_o);
        rst_n_i = 1'h1;
        n = 0;
        while (int_rst_n_o !== 1'h1 && n < 50)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("por_len", 8'(POR_SIM + 1), 8'(n));
        chk("phy_on", 8'h0f, {3'h0, standby_o, phy_en_o, diff_oe_o, osc_en_o,
            pll_en_o});
        tick(1);
    endtask

    // src 0 usb command, 1 runtime register, 2 swap pin
    task automatic swap_step(int src, logic v, logic [3:0] d);
        logic old;
        old = role_swap_state_out_o;
        dly = d;
        if (src == 0)
        begin
            usb_swap_i = v;
            usb_swap_wr_i = 1'h1;
        end
        else if (src == 1)
        begin
            cfg_swap_i = v;
            cfg_swap_wr_i = 1'h1;
        end
        else
            role_swap_cmd_in_i = v;
        tick(1);
        usb_swap_wr_i = 1'h0;
        cfg_swap_wr_i = 1'h0;
        n = 0;
        while (swap_req_o !== v && n < 8)
        begin
            tick(1);
            n++;
        end
        chk("swap_req", {7'h0, v}, {7'h0, swap_req_o});
        chk("state_early", {7'h0, old}, {7'h0, role_swap_state_out_o});
        n = 0;
        while (role_swap_state_out_o !== v && n < 24)
        begin
            tick(1);
            n++;
        end
        chk("state", {7'h0, v}, {7'h0, role_swap_state_out_o});
        chk("upstream", {7'h0, v}, {7'h0, upstream_sel_o});
    endtask

    // one request pulse, then count cycles until the target state shows
    task automatic lpm_go(logic a, logic b, logic c, hrp_lpm_e t, int lo, int hi, string nm);
        l1_req_i = a;
        l2_req_i = b;
        resume_i = c;
        tick(1);
        {l1_req_i, l2_req_i, resume_i} = 3'h0;
        n = 0;
        while (lpm_state_o !== t && n < 1000)
        begin
            tick(1);
            n++;
        end
        chk_lpm(nm, t, lpm_state_o);
        chk(nm, 8'h01, {7'h0, n >= lo && n <= hi});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        do_reset();
        repeat (6)
        begin
            r = xs();
            attach_i = r[3:0];
            tick(4);
            chk("clk_en", {4'h0, attach_i}, {4'h0, phy_clk_en_o});
        end
        // register swap is refused until configuration has ended
        cfg_swap_i = 1'h1;
        cfg_swap_wr_i = 1'h1;
        tick(1);
        cfg_swap_wr_i = 1'h0;
        tick(3);
        chk("cfg_refused", 8'h00, {7'h0, swap_req_o});
        r = xs();
        cfg_addr_i = r[7:0] & 8'hfe;
        cfg_wr_i = 1'h1;
        tick(1);
        chk("cfg_stage", 8'h01, {7'h0, cfg_stage_o});
        cfg_addr_i = CFG_END_REG;
        tick(1);
        cfg_wr_i = 1'h0;
        chk("cfg_end", 8'h00, {7'h0, cfg_stage_o});
        for (int s = 0; s < 3; s++)
        begin
            r = xs();
            swap_step(s, 1'h1, r[3:0]);
            swap_step(s, 1'h0, r[7:4]);
        end
        swap_step(0, 1'h1, 4'h0);
        // usb command and register on one edge: the usb command wins
        dly = 4'hf;
        {cfg_swap_i, usb_swap_i, cfg_swap_wr_i, usb_swap_wr_i} = 4'hb;
        tick(1);
        {cfg_swap_wr_i, usb_swap_wr_i} = 2'h0;
        chk("swap_prio", 8'h00, {7'h0, swap_req_o});
        chk("prio_hold", 8'h01, {7'h0, role_swap_state_out_o});
        // a reset taken in the swapped role must drop back to default
        do_reset();
        lpm_go(1'h1, 1'h0, 1'h0, HRP_L1, 2, 99, "l1_in");
        lpm_go(1'h0, 1'h0, 1'h1, HRP_L0, 2, 499, "l1_out");
        lpm_go(1'h0, 1'h1, 1'h0, HRP_L2, L2_SIM, L2_SIM + 3, "l2_in");
        lpm_go(1'h0, 1'h0, 1'h1, HRP_L0, L2_SIM, L2_SIM + 3, "l2_out");
        lpm_go(1'h0, 1'h1, 1'h0, HRP_L2, L2_SIM, L2_SIM + 3, "l2_again");
        bus_reset_i = 1'h1;
        tick(1);
        bus_reset_i = 1'h0;
        chk_lpm("bus_wake", HRP_L0, lpm_state_o);
        chk("addr", {1'h0, USB_ADDR_DFLT}, {1'h0, usb_addr_o});
        chk("cfgd_ds", 8'h00, {6'h0, configured_o, ds_reset_o});
        close_out();
    end

    // the whole sequence needs under a thousand cycles; this cuts a hang short
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end
endmodule
